// [hw/redriver_pm_map.svh]
`ifndef REDRIVER_PM_MAP_SVH
`define REDRIVER_PM_MAP_SVH

// Device register offsets
`define MODE_PWR_OFS 8'h09
`define SWING_PRE_OFS 8'h0c
`define LANE_RATE_OFS 8'h30
// Field positions in mode_and_power_control
`define MP_ALT_MODE_BIT 5
`define MP_PWRDN_BIT 3
`define MP_CLK_ONLY_BIT 2
`define MP_CLK_RATIO_BIT 1
// Reset values and alternate-mode presets
`define MODE_PWR_RST 8'h00
`define SWING_PRE_RST 8'h00
`define LANE_RATE_RST 8'h00
`define ALT_SWING_PRE 8'h00
`define ALT_LANE_RATE 8'hfc
// Timing: clk period in ns, hot plug low time, clock examination window
`define CLK_PERIOD_NS 25
`define HPD_LOW_NS 2000000
`define EXAM_MIN_NS 3000
`define EXAM_MAX_NS 5000
`define HPD_LOW_CYC ((`HPD_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1)
`define EXAM_CYC ((`EXAM_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Controller register offsets on the Avalon side (byte addresses)
`define CTL_CMD_OFS 4'h0
`define CTL_ADDR_OFS 4'h4
`define CTL_WDATA_OFS 4'h8
`define CTL_STAT_OFS 4'hc

`endif

// [hw/redriver_pm_pkg.sv]
package redriver_pm_pkg;
    typedef enum logic [3:0] {
        PM_DOWN = 4'b0001,
        PM_STBY1 = 4'b0010,
        PM_STBY2 = 4'b0100,
        PM_NORMAL = 4'b1000
    } pm_state_e;
    typedef enum logic [2:0] {
        CT_IDLE = 3'b001,
        CT_WAIT = 3'b010,
        CT_DONE = 3'b100
    } ctl_state_e;
endpackage : redriver_pm_pkg

// [hw/redriver_link_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface redriver_link_if;
    logic oe;
    logic sink_hotplug_in;
    logic source_hotplug_out;
    logic clk_lane;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_ack;
    modport device (
        input oe, sink_hotplug_in, clk_lane, reg_wr, reg_rd, reg_addr,
        input reg_wdata,
        output source_hotplug_out, reg_rdata, reg_ack
    );
    modport host (
        output oe, reg_wr, reg_rd, reg_addr, reg_wdata,
        input source_hotplug_out, reg_rdata, reg_ack, sink_hotplug_in,
        input clk_lane
    );
endinterface : redriver_link_if
`default_nettype wire

// [hw/redriver_power_mode_control.sv]
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "redriver_pm_map.svh"

// Overview of operation
// - Register 09h bit 5 enters alternate mode
// - Alternate mode loads presets, ignores straps
// - No link training; aux bypasses logic
// - Alternate entry enables four lanes, 5.4G
// - Reg 0Ch[7:5] sets swing, all lanes
// - Reg 0Ch[1:0] sets pre-emphasis, all lanes
// - Reg 30h[7:2] lane enables and rate
// - Output-enable low gives full power-down
// - Output-enable rising edge resets configuration
// - Host rewrites configuration after that reset
// - Writing 09h bit 3 powers down
// - Hot plug low over 2 ms powers down
// - Hot plug high without clock: standby
// - Outputs follow clock-lane detector result
// - Source hot plug mirrors sink hot plug
// - Power-down clears all registers
// - Source rewrites clock ratio bit
// - Ratio bit write sets device copy
// - Clock lane examined 3 to 5 us
// - Clock found: normal, else stage one
// - Standby disables data receivers, outputs off
// - 09h bit 2 makes hot plug irrelevant
module redriver_power_mode_control #(
    parameter int HPD_LOW_CYCLES = `HPD_LOW_CYC,
    parameter int EXAM_CYCLES = `EXAM_CYC,
    parameter int MIN_EDGES = 4
) (
    // System
    input wire logic clk,
    input wire logic sys_rst,
    // Link
    redriver_link_if.device link,
    // Strap and status
    input wire logic [7:0] strap_swing_pre,
    output logic rx_data_en,
    output logic rx_clk_en,
    output logic tx_en,
    output logic ddc_en,
    output logic alt_mode,
    output logic [2:0] swing,
    output logic [1:0] preemph,
    output logic [5:0] lane_rate,
    output logic [3:0] pm_state
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0] oe_s, hpd_s, ck_s;
    logic oe_q, ck_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            oe_s <= 2'h0;
            hpd_s <= 2'h0;
            ck_s <= 2'h0;
            oe_q <= 1'b0;
            ck_q <= 1'b0;
        end else begin
            oe_s <= {oe_s[0], link.oe};
            hpd_s <= {hpd_s[0], link.sink_hotplug_in};
            ck_s <= {ck_s[0], link.clk_lane};
            oe_q <= oe_s[1];
            ck_q <= ck_s[1];
        end
    end
    logic oe_rise, ck_edge, oe_on, hpd_on;
    assign oe_on = oe_s[1];
    assign hpd_on = hpd_s[1];
    assign oe_rise = oe_s[1] & ~oe_q;
    assign ck_edge = ck_s[1] ^ ck_q;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] mode_and_power_control;
    logic [7:0] global_swing_preemphasis;
    logic [7:0] lane_enable_and_rate;
    logic in_down, clr_regs, enter_down, wr_mp, wr_sp, wr_lr;
    redriver_pm_pkg::pm_state_e st;
    assign in_down = (st == redriver_pm_pkg::PM_DOWN);
    // Oe low or rising holds everything at defaults
    assign clr_regs = ~oe_on | oe_rise;
    assign wr_mp = link.reg_wr & (link.reg_addr == `MODE_PWR_OFS);
    assign wr_sp = link.reg_wr & (link.reg_addr == `SWING_PRE_OFS);
    assign wr_lr = link.reg_wr & (link.reg_addr == `LANE_RATE_OFS);

    always_ff @(posedge clk) begin
        if (sys_rst || clr_regs || enter_down) begin
            mode_and_power_control <= `MODE_PWR_RST;
        end else if (wr_mp) begin
            // Ratio bit copy follows the source's write
            mode_and_power_control <= link.reg_wdata;
        end else if (mode_and_power_control[`MP_PWRDN_BIT]) begin
            // Self-clearing: power-down clears every register
            mode_and_power_control <= `MODE_PWR_RST;
        end
    end

    logic alt_enter;
    assign alt_enter = wr_mp & link.reg_wdata[`MP_ALT_MODE_BIT]
                       & ~mode_and_power_control[`MP_ALT_MODE_BIT];

    always_ff @(posedge clk) begin
        if (sys_rst || clr_regs || enter_down
            || mode_and_power_control[`MP_PWRDN_BIT]) begin
            global_swing_preemphasis <= `SWING_PRE_RST;
            lane_enable_and_rate <= `LANE_RATE_RST;
        end else if (alt_enter) begin
            global_swing_preemphasis <= `ALT_SWING_PRE;
            lane_enable_and_rate <= `ALT_LANE_RATE;
        end else begin
            if (wr_sp) begin
                global_swing_preemphasis <= link.reg_wdata;
            end
            if (wr_lr) begin
                lane_enable_and_rate <= link.reg_wdata;
            end
        end
    end

    // Register read port: one-cycle acknowledge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            link.reg_ack <= 1'b0;
            link.reg_rdata <= 8'h00;
        end else begin
            link.reg_ack <= link.reg_wr | link.reg_rd;
            if (link.reg_addr == `MODE_PWR_OFS) begin
                link.reg_rdata <= mode_and_power_control;
            end else if (link.reg_addr == `SWING_PRE_OFS) begin
                link.reg_rdata <= global_swing_preemphasis;
            end else if (link.reg_addr == `LANE_RATE_OFS) begin
                link.reg_rdata <= lane_enable_and_rate;
            end else begin
                link.reg_rdata <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------
    logic [21:0] hpd_cnt;
    logic hpd_expired;
    always_ff @(posedge clk) begin
        if (sys_rst || hpd_on || !oe_on) begin
            hpd_cnt <= 22'h0;
        end else if (!hpd_expired) begin
            hpd_cnt <= hpd_cnt + 22'h1;
        end
    end
    assign hpd_expired = (hpd_cnt >= 22'(HPD_LOW_CYCLES));

    logic [12:0] ex_cnt;
    logic [7:0] edge_cnt;
    always_ff @(posedge clk) begin
        if (sys_rst || st != redriver_pm_pkg::PM_STBY2) begin
            ex_cnt <= 13'h0;
            edge_cnt <= 8'h0;
        end else begin
            ex_cnt <= ex_cnt + 13'h1;
            if (ck_edge && edge_cnt != 8'hff) begin
                edge_cnt <= edge_cnt + 8'h1;
            end
        end
    end
    logic ex_done, ck_found;
    assign ex_done = (ex_cnt >= 13'(EXAM_CYCLES));
    assign ck_found = (edge_cnt >= 8'(MIN_EDGES));

    // ------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------
    logic go_down, hpd_ok;
    assign hpd_ok = mode_and_power_control[`MP_CLK_ONLY_BIT] | hpd_on;
    assign go_down = ~oe_on | mode_and_power_control[`MP_PWRDN_BIT]
                     | (~mode_and_power_control[`MP_CLK_ONLY_BIT]
                        & hpd_expired);
    // Any path into power-down wipes the registers, hot plug loss too
    assign enter_down = go_down & ~in_down;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= redriver_pm_pkg::PM_DOWN;
        end else if (go_down) begin
            st <= redriver_pm_pkg::PM_DOWN;
        end else begin
            case (st)
                redriver_pm_pkg::PM_DOWN: begin
                    if (hpd_ok) st <= redriver_pm_pkg::PM_STBY1;
                end
                redriver_pm_pkg::PM_STBY1: begin
                    if (hpd_ok && ck_edge) begin
                        st <= redriver_pm_pkg::PM_STBY2;
                    end
                end
                redriver_pm_pkg::PM_STBY2: begin
                    if (ex_done) begin
                        st <= ck_found ? redriver_pm_pkg::PM_NORMAL
                                       : redriver_pm_pkg::PM_STBY1;
                    end
                end
                redriver_pm_pkg::PM_NORMAL: begin
                    if (!hpd_ok) st <= redriver_pm_pkg::PM_STBY1;
                end
                default: st <= redriver_pm_pkg::PM_DOWN;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            link.source_hotplug_out <= 1'b0;
            rx_data_en <= 1'b0;
            rx_clk_en <= 1'b0;
            tx_en <= 1'b0;
            ddc_en <= 1'b0;
            alt_mode <= 1'b0;
            swing <= 3'h0;
            preemph <= 2'h0;
            lane_rate <= 6'h0;
            pm_state <= 4'h1;
        end else begin
            link.source_hotplug_out <= hpd_on;
            rx_data_en <= (st == redriver_pm_pkg::PM_NORMAL);
            rx_clk_en <= ~in_down;
            tx_en <= (st == redriver_pm_pkg::PM_NORMAL);
            // Delayed one stage so it moves together with pm_state
            ddc_en <= oe_q;
            // Aux channel and training are outside this logic
            alt_mode <= mode_and_power_control[`MP_ALT_MODE_BIT];
            if (mode_and_power_control[`MP_ALT_MODE_BIT]) begin
                swing <= global_swing_preemphasis[7:5];
                preemph <= global_swing_preemphasis[1:0];
            end else begin
                swing <= strap_swing_pre[7:5];
                preemph <= strap_swing_pre[1:0];
            end
            lane_rate <= lane_enable_and_rate[7:2];
            pm_state <= st;
        end
    end
endmodule : redriver_power_mode_control
`default_nettype wire

// [hw/redriver_host_ctl.sv]
`timescale 1ns/100ps
`default_nettype none
`include "redriver_pm_map.svh"

// Host end: Avalon-MM slave that issues device register accesses.
module redriver_host_ctl (
    // System
    input wire logic clk,
    input wire logic sys_rst,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Link
    redriver_link_if.host link
);
    logic [7:0] dev_addr, dev_wdata, dev_rdata;
    logic oe_reg, busy, go, is_rd;
    redriver_pm_pkg::ctl_state_e st;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end else begin
            avs_waitrequest <= ~(avs_read | avs_write) | ~avs_waitrequest;
            if (avs_read && avs_waitrequest) begin
                if (avs_address == `CTL_CMD_OFS) begin
                    avs_readdata <= {31'h0, oe_reg};
                end else if (avs_address == `CTL_ADDR_OFS) begin
                    avs_readdata <= {24'h0, dev_addr};
                end else if (avs_address == `CTL_WDATA_OFS) begin
                    avs_readdata <= {24'h0, dev_wdata};
                end else if (avs_address == `CTL_STAT_OFS) begin
                    avs_readdata <= {22'h0, link.source_hotplug_out, busy,
                                     dev_rdata};
                end else begin
                    avs_readdata <= 32'h0;
                end
            end
        end
    end

    logic acc;
    // A write lands only at the edge where waitrequest is seen low
    assign acc = avs_write & ~avs_waitrequest;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            oe_reg <= 1'b0;
            dev_addr <= 8'h0;
            dev_wdata <= 8'h0;
            go <= 1'b0;
            is_rd <= 1'b0;
        end else begin
            go <= 1'b0;
            if (acc && avs_address == `CTL_CMD_OFS) begin
                // Bit0 output enable, bit1 write go, bit2 read go
                oe_reg <= avs_writedata[0];
                go <= (avs_writedata[1] | avs_writedata[2]) & ~busy;
                is_rd <= avs_writedata[2];
            end else if (acc && avs_address == `CTL_ADDR_OFS) begin
                dev_addr <= avs_writedata[7:0];
            end else if (acc && avs_address == `CTL_WDATA_OFS) begin
                dev_wdata <= avs_writedata[7:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= redriver_pm_pkg::CT_IDLE;
            link.reg_wr <= 1'b0;
            link.reg_rd <= 1'b0;
            dev_rdata <= 8'h0;
        end else begin
            case (st)
                redriver_pm_pkg::CT_IDLE: begin
                    if (go) begin
                        link.reg_wr <= ~is_rd;
                        link.reg_rd <= is_rd;
                        st <= redriver_pm_pkg::CT_WAIT;
                    end
                end
                redriver_pm_pkg::CT_WAIT: begin
                    link.reg_wr <= 1'b0;
                    link.reg_rd <= 1'b0;
                    st <= redriver_pm_pkg::CT_DONE;
                end
                redriver_pm_pkg::CT_DONE: begin
                    if (link.reg_ack) begin
                        dev_rdata <= link.reg_rdata;
                        st <= redriver_pm_pkg::CT_IDLE;
                    end
                end
                default: st <= redriver_pm_pkg::CT_IDLE;
            endcase
        end
    end
    assign busy = (st != redriver_pm_pkg::CT_IDLE);
    assign link.oe = oe_reg;
    assign link.reg_addr = dev_addr;
    assign link.reg_wdata = dev_wdata;
endmodule : redriver_host_ctl
`default_nettype wire

// [testbench/redriver_pm_props.sv]
`timescale 1ns/100ps
`default_nettype none
module redriver_pm_props #(
    parameter int EXAM_CYCLES = 120
) (
    // System
    input wire logic clk,
    input wire logic sys_rst,
    // Link
    input wire logic oe,
    input wire logic sink_hotplug_in,
    input wire logic source_hotplug_out,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_ack,
    // Device status
    input wire logic [3:0] pm_state,
    input wire logic tx_en,
    input wire logic rx_data_en,
    input wire logic rx_clk_en,
    input wire logic ddc_en,
    input wire logic alt_mode,
    input wire logic [5:0] lane_rate
);
    // Longest examination, 5 us
    localparam int EXAM_MAX = 200;
    logic [8:0] exam_cnt;
    logic in_exam;
    logic in_stby;
    assign in_exam = pm_state == redriver_pm_pkg::PM_STBY2;
    assign in_stby = in_exam || pm_state == redriver_pm_pkg::PM_STBY1;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge clk) begin
        if (sys_rst || !in_exam) begin
            exam_cnt <= 9'h0;
        end else begin
            exam_cnt <= exam_cnt + 9'h1;
        end
    end
    // --------
    // Checks
    // --------
    hpd_mirror_a: assert property (
        $stable(sink_hotplug_in) [*6] |-> source_hotplug_out == sink_hotplug_in
    ) else $error("source hot plug differs from sink");
    oe_down_a: assert property (
        !oe [*6] |-> pm_state == redriver_pm_pkg::PM_DOWN && !tx_en && !ddc_en
            && !rx_data_en && !rx_clk_en && !alt_mode
    ) else $error("device active while output enable low");
    stby_outputs_a: assert property (
        in_stby [*2] |-> !tx_en && !rx_data_en && rx_clk_en && ddc_en
    ) else $error("wrong enables in standby");
    normal_outputs_a: assert property (
        (pm_state == redriver_pm_pkg::PM_NORMAL) [*2]
            |-> tx_en && rx_data_en && rx_clk_en && ddc_en
    ) else $error("wrong enables in normal operation");
    alt_preset_a: assert property (
        $rose(alt_mode) |-> ##[0:2] lane_rate == 6'h3f
    ) else $error("alternate mode left lanes off");
    exam_max_a: assert property (
        exam_cnt <= EXAM_MAX
    ) else $error("clock examination too long");
    exam_min_a: assert property (
        $fell(in_exam) && pm_state != redriver_pm_pkg::PM_DOWN
            |-> exam_cnt >= EXAM_CYCLES - 1
    ) else $error("clock examination too short");
    reg_ack_a: assert property (
        reg_wr || reg_rd |=> reg_ack ##1 !reg_ack
    ) else $error("register answer not one cycle later");
    cover property (pm_state == redriver_pm_pkg::PM_NORMAL);
    cover property ($rose(alt_mode));
    cover property ($fell(in_exam) && pm_state == redriver_pm_pkg::PM_STBY1);
endmodule : redriver_pm_props
`default_nettype wire

// [testbench/redriver_power_mode_control_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "redriver_pm_map.svh"
module redriver_power_mode_control_tb;
    // Hot plug low time shortened to keep the run brief
    localparam int HPD_LOW = 50;
    localparam logic [3:0] DN = redriver_pm_pkg::PM_DOWN;
    localparam logic [3:0] SB1 = redriver_pm_pkg::PM_STBY1;
    localparam logic [3:0] SB2 = redriver_pm_pkg::PM_STBY2;
    localparam logic [3:0] NRM = redriver_pm_pkg::PM_NORMAL;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [7:0] strap_swing_pre = 8'h00;
    logic rx_data_en, rx_clk_en, tx_en, ddc_en, alt_mode;
    logic [2:0] swing;
    logic [1:0] preemph;
    logic [5:0] lane_rate;
    logic [3:0] pm_state;
    logic lane_on = 1'b0;
    logic oe_bit = 1'b0;
    logic pd_seen = 1'b0;
    logic [31:0] rd;
    logic [7:0] r;
    logic [7:0] ofs [3] = '{`MODE_PWR_OFS, `SWING_PRE_OFS, `LANE_RATE_OFS};
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;
    redriver_link_if link_if();
    redriver_power_mode_control #(.HPD_LOW_CYCLES(HPD_LOW))
        redriver_power_mode_control_inst (.clk(clk), .sys_rst(sys_rst),
        .link(link_if), .strap_swing_pre(strap_swing_pre),
        .rx_data_en(rx_data_en), .rx_clk_en(rx_clk_en), .tx_en(tx_en),
        .ddc_en(ddc_en), .alt_mode(alt_mode), .swing(swing),
        .preemph(preemph), .lane_rate(lane_rate), .pm_state(pm_state));
    redriver_host_ctl redriver_host_ctl_inst (.clk(clk), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .link(link_if));
    redriver_pm_props #(.EXAM_CYCLES(`EXAM_CYC)) redriver_pm_props_inst (
        .clk(clk), .sys_rst(sys_rst), .oe(link_if.oe),
        .sink_hotplug_in(link_if.sink_hotplug_in),
        .source_hotplug_out(link_if.source_hotplug_out),
        .reg_wr(link_if.reg_wr), .reg_rd(link_if.reg_rd),
        .reg_ack(link_if.reg_ack), .pm_state(pm_state), .tx_en(tx_en),
        .rx_data_en(rx_data_en), .rx_clk_en(rx_clk_en), .ddc_en(ddc_en),
        .alt_mode(alt_mode), .lane_rate(lane_rate));
    always #12.5 clk = ~clk;
    // Lane clock is unrelated in phase and stands still when off
    initial begin
        #7;
        forever begin
            #100;
            if (lane_on) link_if.clk_lane = ~link_if.clk_lane;
        end
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (pm_state === DN) pd_seen <= 1'b1;
        if (cycles == 40000) begin
            fails++;
            complete_run();
        end
    end
    // --------
    // Tasks
    // --------
    task complete_run;
        if (fails == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, g, e);
        end
    endtask : chk
    task av(input logic [3:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : av
    // Device access; busy is polled, read byte lands in rd
    task dev(input logic w, input logic [7:0] a, input logic [7:0] d);
        av(4'h4, 1'b1, {24'h0, a});
        if (w) av(4'h8, 1'b1, {24'h0, d});
        av(4'h0, 1'b1, {29'h0, !w, w, oe_bit});
        rd = 32'h100;
        while (rd[8] !== 1'b0) av(4'hc, 1'b0, 32'h0);
    endtask : dev
    task set_oe(input logic v);
        oe_bit = v;
        av(4'h0, 1'b1, {31'h0, v});
    endtask : set_oe
    task wait_pm(input logic [3:0] e, input int lim);
        for (int i = 0; i < lim && pm_state !== e; i++) @(posedge clk);
        chk(pm_state, e);
    endtask : wait_pm
    initial begin
        link_if.sink_hotplug_in = 1'b0;
        link_if.clk_lane = 1'b0;
        void'($urandom(99));
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk(pm_state, DN);
        set_oe(1'b1);
        link_if.sink_hotplug_in <= 1'b1;
        wait_pm(SB1, 20);
        foreach (ofs[i]) begin
            dev(1'b0, ofs[i], 8'h00);
            chk(rd[7:0], 8'h00);
        end
        dev(1'b1, `MODE_PWR_OFS, 8'h20);
        chk(alt_mode, 1'b1);
        dev(1'b0, `LANE_RATE_OFS, 8'h00);
        chk(rd[7:0], `ALT_LANE_RATE);
        dev(1'b0, `SWING_PRE_OFS, 8'h00);
        chk(rd[7:0], `ALT_SWING_PRE);
        for (int i = 0; i < 6; i++) begin
            r = i == 0 ? 8'hff : 8'($urandom);
            strap_swing_pre <= ~r;
            dev(1'b1, `SWING_PRE_OFS, r);
            chk(swing, r[7:5]);
            chk(preemph, r[1:0]);
            dev(1'b1, `LANE_RATE_OFS, r);
            chk(lane_rate, r[7:2]);
        end
        // A lone edge is noise, not a clock
        link_if.clk_lane <= 1'b1;
        wait_pm(SB2, 10);
        wait_pm(SB1, 220);
        lane_on = 1'b1;
        wait_pm(NRM, 250);
        link_if.sink_hotplug_in <= 1'b0;
        repeat (HPD_LOW - 10) @(posedge clk);
        chk(pm_state == DN, 1'b0);
        chk(link_if.source_hotplug_out, 1'b0);
        link_if.sink_hotplug_in <= 1'b1;
        repeat (4) @(posedge clk);
        link_if.sink_hotplug_in <= 1'b0;
        repeat (HPD_LOW - 10) @(posedge clk);
        chk(pm_state == DN, 1'b0);
        wait_pm(DN, 30);
        chk(alt_mode, 1'b0);
        dev(1'b1, `MODE_PWR_OFS, 8'h04);
        wait_pm(NRM, 250);
        repeat (HPD_LOW + 20) @(posedge clk);
        chk(pm_state, NRM);
        link_if.sink_hotplug_in <= 1'b1;
        dev(1'b1, `SWING_PRE_OFS, 8'h5a);
        dev(1'b1, `MODE_PWR_OFS, 8'h06);
        dev(1'b0, `MODE_PWR_OFS, 8'h00);
        chk(rd[7:0], 8'h06);
        pd_seen = 1'b0;
        dev(1'b1, `MODE_PWR_OFS, 8'h08);
        chk(pd_seen, 1'b1);
        foreach (ofs[i]) begin
            dev(1'b0, ofs[i], 8'h00);
            chk(rd[7:0], 8'h00);
        end
        dev(1'b1, `MODE_PWR_OFS, 8'h02);
        dev(1'b0, `MODE_PWR_OFS, 8'h00);
        chk(rd[7:0], 8'h02);
        set_oe(1'b0);
        wait_pm(DN, 10);
        av(4'hc, 1'b0, 32'h0);
        chk(rd[9], 1'b1);
        set_oe(1'b1);
        dev(1'b0, `MODE_PWR_OFS, 8'h00);
        chk(rd[7:0], 8'h00);
        dev(1'b1, `MODE_PWR_OFS, 8'h20);
        chk(alt_mode, 1'b1);
        complete_run();
    end
endmodule : redriver_power_mode_control_tb
`default_nettype wire
